//--- pfl_cap_value.sv
// Converts the C1 selection code into its capacitance in pF.
// Assumes the code input is a registered value.
`include "pfl_defs.svh"

module pfl_cap_value (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Code in, value out
	input  wire logic [2:0] code_i,
	output logic      [8:0] pf_o
);
	import pfl_pkg::*;

	pfl_cap_t s_r;
	pfl_cap_t s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.pf = `PFL_C1_BASE_PF + `PFL_C1_STEP_PF * 9'(code_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pf_o = s_r.pf;

endmodule : pfl_cap_value

//--- pfl_defs.svh
// Register indices, reset values and field positions of the fractional loop register bank.
// Assumes a 32-bit classic Wishbone slave with one aligned word per register.
`ifndef PFL_DEFS_SVH
`define PFL_DEFS_SVH

// Register indices; byte address is four times the index
`define PFL_IDX_NDIV_HI   8'h49
`define PFL_IDX_NDIV_LO   8'h4A
`define PFL_IDX_NUM_U     8'h4B
`define PFL_IDX_NUM_M     8'h4C
`define PFL_IDX_NUM_L     8'h4D
`define PFL_IDX_DEN_U     8'h4E
`define PFL_IDX_DEN_M     8'h4F
`define PFL_IDX_DEN_L     8'h50
`define PFL_IDX_MOD       8'h51
`define PFL_IDX_R2        8'h52
`define PFL_IDX_C1        8'h53
`define PFL_IDX_R3        8'h54

// Bus address slicing
`define PFL_ADR_IDX       9:2
`define PFL_ADR_HIGH      31:10
`define PFL_ADR_HIGH_ZERO 22'h000000
`define PFL_SEL_LOW       0

// Field positions
`define PFL_BYTE_FLD      7:0
`define PFL_UPPER_FLD     5:0
`define PFL_NDIV_HI_FLD   3:0
`define PFL_DITHER_FLD    3:2
`define PFL_ORDER_FLD     1:0
`define PFL_R2_FLD        5:0
`define PFL_C1_FLD        2:0
`define PFL_R3_FLD        6:0

// Reset values
`define PFL_RST_NDIV_HI   4'h0
`define PFL_RST_NDIV_LO   8'h64
`define PFL_RST_UPPER     6'h00
`define PFL_RST_BYTE      8'h00
`define PFL_RST_R2        6'h24
`define PFL_RST_C1        3'h0
`define PFL_RST_R3        7'h00
`define PFL_RST_WORD      32'h00000000

// Capacitor C1 value: base plus step times code, in pF
`define PFL_C1_BASE_PF    9'h005
`define PFL_C1_STEP_PF    9'h032

`endif

//--- pfl_frac_loop_regs.sv
// Configuration registers for the second synthesizer's fractional divider and loop filter.
// Assumes a classic Wishbone master on a 32-bit bus, synchronous to clk_i.
//
// Behaviour
// - Numerator is 22 bits: upper reg bits 5:0, middle, lower bytes.
// - Denominator is 22 bits: upper reg bits 5:0, middle, lower bytes.
// - Numerator and denominator bytes are read/write and reset to zero.
// - Dither field bits 3:2: weak, medium, strong, off; resets to off.
// - Order field bits 1:0: integer, first, second, third order; resets to integer.
// - R2 code bits 5:0 read/write, resets to 0x24.
// - C1 code bits 2:0 read/write, value 5 pF plus 50 pF per step.
// - R3 code bits 6:0 read/write selects loop resistor three.
// - Integer feedback divider is 12 bits over two neighbouring registers.
`include "pfl_defs.svh"

module pfl_frac_loop_regs (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [31:0]         wb_adr_i,
	input  wire logic [31:0]         wb_dat_i,
	input  wire logic [3:0]          wb_sel_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// Fractional divider
	output logic      [21:0]         frac_numerator_o,
	output logic      [21:0]         frac_denominator_o,
	output logic      [11:0]         integer_feedback_divider_o,
	output pfl_pkg::pfl_dither_t     dither_strength_o,
	output pfl_pkg::pfl_order_t      modulator_order_o,
	output logic                     integer_mode_o,
	output logic                     dither_enable_o,
	// Loop filter
	output logic      [5:0]          loop_resistor_two_code_o,
	output logic      [2:0]          loop_capacitor_one_code_o,
	output logic      [8:0]          loop_capacitor_one_pf_o,
	output logic      [6:0]          loop_resistor_three_code_o
);
	import pfl_pkg::*;

	localparam pfl_state_t PFL_RESET = '{
		ndiv_hi:  `PFL_RST_NDIV_HI,
		ndiv_lo:  `PFL_RST_NDIV_LO,
		num_u:    `PFL_RST_UPPER,
		num_m:    `PFL_RST_BYTE,
		num_l:    `PFL_RST_BYTE,
		den_u:    `PFL_RST_UPPER,
		den_m:    `PFL_RST_BYTE,
		den_l:    `PFL_RST_BYTE,
		dither:   PFL_DITHER_OFF,
		order:    PFL_ORDER_INTEGER,
		r2:       `PFL_RST_R2,
		c1:       `PFL_RST_C1,
		r3:       `PFL_RST_R3,
		dat:      `PFL_RST_WORD,
		num:      {`PFL_RST_UPPER, `PFL_RST_BYTE, `PFL_RST_BYTE},
		den:      {`PFL_RST_UPPER, `PFL_RST_BYTE, `PFL_RST_BYTE},
		ndiv:     {`PFL_RST_NDIV_HI, `PFL_RST_NDIV_LO},
		int_mode: 1'b1,
		dith_en:  1'b0
	};

	pfl_state_t s_r;
	pfl_state_t s_nxt;
	logic       take;
	logic       ack;
	logic [7:0] idx;
	logic       mapped;
	logic       wr_go;

	// Handshake
	pfl_wb_ack u_ack (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cyc_i  (wb_cyc_i),
		.stb_i  (wb_stb_i),
		.take_o (take),
		.ack_o  (ack)
	);

	// Capacitance readout for C1
	pfl_cap_value u_cap (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.code_i (s_r.c1),
		.pf_o   (loop_capacitor_one_pf_o)
	);

	// Index decode; anything above the window is unmapped
	assign idx    = wb_adr_i[`PFL_ADR_IDX];
	assign mapped = (wb_adr_i[`PFL_ADR_HIGH] == `PFL_ADR_HIGH_ZERO);
	// Only the low byte lane holds data, so only sel[0] enables a write
	assign wr_go  = take && wb_we_i && wb_sel_i[`PFL_SEL_LOW] && mapped;

	function automatic logic pfl_hit(input logic go, input logic [7:0] at, input logic [7:0] want);
		return go && (at == want);
	endfunction : pfl_hit

	// Read view of one register; reserved bits come back as zero
	function automatic logic [31:0] pfl_read(input pfl_state_t s, input logic [7:0] at);
		logic [7:0] b;
		b = `PFL_RST_BYTE;
		if (at == `PFL_IDX_NDIV_HI) begin
			b = 8'(s.ndiv_hi);
		end else if (at == `PFL_IDX_NDIV_LO) begin
			b = s.ndiv_lo;
		end else if (at == `PFL_IDX_NUM_U) begin
			b = 8'(s.num_u);
		end else if (at == `PFL_IDX_NUM_M) begin
			b = s.num_m;
		end else if (at == `PFL_IDX_NUM_L) begin
			b = s.num_l;
		end else if (at == `PFL_IDX_DEN_U) begin
			b = 8'(s.den_u);
		end else if (at == `PFL_IDX_DEN_M) begin
			b = s.den_m;
		end else if (at == `PFL_IDX_DEN_L) begin
			b = s.den_l;
		end else if (at == `PFL_IDX_MOD) begin
			b = 8'({s.dither, s.order});
		end else if (at == `PFL_IDX_R2) begin
			b = 8'(s.r2);
		end else if (at == `PFL_IDX_C1) begin
			b = 8'(s.c1);
		end else if (at == `PFL_IDX_R3) begin
			b = 8'(s.r3);
		end
		return 32'(b);
	endfunction : pfl_read

	always_comb begin
		s_nxt = s_r;
		// Field writes take only the documented bits
		if (pfl_hit(wr_go, idx, `PFL_IDX_NDIV_HI)) begin
			s_nxt.ndiv_hi = wb_dat_i[`PFL_NDIV_HI_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_NDIV_LO)) begin
			s_nxt.ndiv_lo = wb_dat_i[`PFL_BYTE_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_NUM_U)) begin
			s_nxt.num_u = wb_dat_i[`PFL_UPPER_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_NUM_M)) begin
			s_nxt.num_m = wb_dat_i[`PFL_BYTE_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_NUM_L)) begin
			s_nxt.num_l = wb_dat_i[`PFL_BYTE_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_DEN_U)) begin
			s_nxt.den_u = wb_dat_i[`PFL_UPPER_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_DEN_M)) begin
			s_nxt.den_m = wb_dat_i[`PFL_BYTE_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_DEN_L)) begin
			s_nxt.den_l = wb_dat_i[`PFL_BYTE_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_MOD)) begin
			s_nxt.dither = pfl_dither_t'(wb_dat_i[`PFL_DITHER_FLD]);
			s_nxt.order  = pfl_order_t'(wb_dat_i[`PFL_ORDER_FLD]);
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_R2)) begin
			s_nxt.r2 = wb_dat_i[`PFL_R2_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_C1)) begin
			s_nxt.c1 = wb_dat_i[`PFL_C1_FLD];
		end
		if (pfl_hit(wr_go, idx, `PFL_IDX_R3)) begin
			s_nxt.r3 = wb_dat_i[`PFL_R3_FLD];
		end
		// Read data: writes and unmapped reads answer zero
		if (take) begin
			s_nxt.dat = (wb_we_i || !mapped) ? `PFL_RST_WORD : pfl_read(s_r, idx);
		end
		// Assembled values lag a register write by one cycle, keeping every output a flop
		s_nxt.num      = {s_r.num_u, s_r.num_m, s_r.num_l};
		s_nxt.den      = {s_r.den_u, s_r.den_m, s_r.den_l};
		s_nxt.ndiv     = {s_r.ndiv_hi, s_r.ndiv_lo};
		s_nxt.int_mode = (s_r.order == PFL_ORDER_INTEGER);
		s_nxt.dith_en  = (s_r.dither != PFL_DITHER_OFF);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= PFL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wb_dat_o                   = s_r.dat;
	assign wb_ack_o                   = ack;
	assign frac_numerator_o           = s_r.num;
	assign frac_denominator_o         = s_r.den;
	assign integer_feedback_divider_o = s_r.ndiv;
	assign dither_strength_o          = s_r.dither;
	assign modulator_order_o          = s_r.order;
	assign integer_mode_o             = s_r.int_mode;
	assign dither_enable_o            = s_r.dith_en;
	assign loop_resistor_two_code_o   = s_r.r2;
	assign loop_capacitor_one_code_o  = s_r.c1;
	assign loop_resistor_three_code_o = s_r.r3;

	// Checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic rd_go;
	assign rd_go = take && !wb_we_i && mapped;

	property p_num_middle;
		pfl_hit(wr_go, idx, `PFL_IDX_NUM_M) |-> ##2 frac_numerator_o[15:8] == $past(wb_dat_i[7:0], 2);
	endproperty
	a_num_middle: assert property (p_num_middle) else $error("numerator middle byte not applied");

	property p_den_upper;
		pfl_hit(wr_go, idx, `PFL_IDX_DEN_U) |-> ##2 frac_denominator_o[21:16] == $past(wb_dat_i[5:0], 2);
	endproperty
	a_den_upper: assert property (p_den_upper) else $error("denominator upper bits not applied");

	property p_num_readback;
		pfl_hit(rd_go, idx, `PFL_IDX_NUM_L) |=> wb_ack_o && wb_dat_o[7:0] == frac_numerator_o[7:0];
	endproperty
	a_num_readback: assert property (p_num_readback) else $error("numerator lower byte read mismatch");

	property p_dither_off;
		pfl_hit(wr_go, idx, `PFL_IDX_MOD) && wb_dat_i[3:2] == 2'h3 |-> ##2 !dither_enable_o;
	endproperty
	a_dither_off: assert property (p_dither_off) else $error("dither code 3 left dither on");

	property p_integer_mode;
		pfl_hit(wr_go, idx, `PFL_IDX_MOD) |-> ##2 integer_mode_o == ($past(wb_dat_i[1:0], 2) == 2'h0);
	endproperty
	a_integer_mode: assert property (p_integer_mode) else $error("integer mode does not follow order");

	property p_reset_values;
		$fell(rst_i) |-> loop_resistor_two_code_o == 6'h24 && dither_strength_o == PFL_DITHER_OFF
			&& modulator_order_o == PFL_ORDER_INTEGER && frac_numerator_o == 22'h0;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

	// The first cycle after reset has no registered code behind the value yet
	property p_c1_value;
		!$past(rst_i) |-> loop_capacitor_one_pf_o
			== `PFL_C1_BASE_PF + `PFL_C1_STEP_PF * 9'($past(loop_capacitor_one_code_o));
	endproperty
	a_c1_value: assert property (p_c1_value) else $error("C1 capacitance wrong");

	property p_r3_write;
		pfl_hit(wr_go, idx, `PFL_IDX_R3) |-> ##2 loop_resistor_three_code_o == $past(wb_dat_i[6:0], 2);
	endproperty
	a_r3_write: assert property (p_r3_write) else $error("R3 code not applied");

	property p_ndiv_high;
		pfl_hit(wr_go, idx, `PFL_IDX_NDIV_HI) |-> ##2 integer_feedback_divider_o[11:8] == $past(wb_dat_i[3:0], 2);
	endproperty
	a_ndiv_high: assert property (p_ndiv_high) else $error("divider high bits not applied");

	property p_reserved_zero;
		pfl_hit(rd_go, idx, `PFL_IDX_C1) |=> wb_dat_o[31:3] == 29'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

	property p_one_ack;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_one_ack: assert property (p_one_ack) else $error("ack held longer than one cycle");

	property p_num_upper;
		pfl_hit(wr_go, idx, `PFL_IDX_NUM_U) |-> ##2 frac_numerator_o[21:16] == $past(wb_dat_i[5:0], 2);
	endproperty
	a_num_upper: assert property (p_num_upper) else $error("numerator upper bits not applied");

	property p_num_lower;
		pfl_hit(wr_go, idx, `PFL_IDX_NUM_L) |-> ##2 frac_numerator_o[7:0] == $past(wb_dat_i[7:0], 2);
	endproperty
	a_num_lower: assert property (p_num_lower) else $error("numerator lower byte not applied");

	property p_den_middle;
		pfl_hit(wr_go, idx, `PFL_IDX_DEN_M) |-> ##2 frac_denominator_o[15:8] == $past(wb_dat_i[7:0], 2);
	endproperty
	a_den_middle: assert property (p_den_middle) else $error("denominator middle byte not applied");

	property p_den_lower;
		pfl_hit(wr_go, idx, `PFL_IDX_DEN_L) |-> ##2 frac_denominator_o[7:0] == $past(wb_dat_i[7:0], 2);
	endproperty
	a_den_lower: assert property (p_den_lower) else $error("denominator lower byte not applied");

	property p_dither_write;
		pfl_hit(wr_go, idx, `PFL_IDX_MOD) |=> dither_strength_o == $past(wb_dat_i[3:2]);
	endproperty
	a_dither_write: assert property (p_dither_write) else $error("dither strength not applied");

	property p_order_write;
		pfl_hit(wr_go, idx, `PFL_IDX_MOD) |=> modulator_order_o == $past(wb_dat_i[1:0]);
	endproperty
	a_order_write: assert property (p_order_write) else $error("modulator order not applied");

	property p_r2_write;
		pfl_hit(wr_go, idx, `PFL_IDX_R2) |=> loop_resistor_two_code_o == $past(wb_dat_i[5:0]);
	endproperty
	a_r2_write: assert property (p_r2_write) else $error("R2 code not applied");

	property p_c1_write;
		pfl_hit(wr_go, idx, `PFL_IDX_C1) |=> loop_capacitor_one_code_o == $past(wb_dat_i[2:0]);
	endproperty
	a_c1_write: assert property (p_c1_write) else $error("C1 code not applied");

	property p_ndiv_low;
		pfl_hit(wr_go, idx, `PFL_IDX_NDIV_LO) |-> ##2 integer_feedback_divider_o[7:0] == $past(wb_dat_i[7:0], 2);
	endproperty
	a_ndiv_low: assert property (p_ndiv_low) else $error("divider low byte not applied");

	property p_reserved_mod;
		pfl_hit(rd_go, idx, `PFL_IDX_MOD) |=> wb_dat_o[31:4] == 28'h0000000;
	endproperty
	a_reserved_mod: assert property (p_reserved_mod) else $error("modulator reserved bits read nonzero");

	property p_reserved_r3;
		pfl_hit(rd_go, idx, `PFL_IDX_R3) |=> wb_dat_o[31:7] == 25'h0000000;
	endproperty
	a_reserved_r3: assert property (p_reserved_r3) else $error("R3 reserved bits read nonzero");

	// Reads, cleared byte enables and unmapped writes must leave the codes alone
	property p_masked_write;
		take && !wr_go |=> $stable(loop_resistor_two_code_o) && $stable(loop_resistor_three_code_o)
			&& $stable(loop_capacitor_one_code_o) && $stable(modulator_order_o);
	endproperty
	a_masked_write: assert property (p_masked_write) else $error("ignored request changed a code");

	property p_write_answer;
		take && wb_we_i |=> wb_dat_o == `PFL_RST_WORD;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write ack carried nonzero data");

	property p_take_ack;
		take |=> wb_ack_o;
	endproperty
	a_take_ack: assert property (p_take_ack) else $error("request taken without ack");

	c_write_mod: cover property (pfl_hit(wr_go, idx, `PFL_IDX_MOD));
	c_read_num: cover property (pfl_hit(rd_go, idx, `PFL_IDX_NUM_U));
	c_third_order: cover property (modulator_order_o == PFL_ORDER_THIRD && dither_enable_o);
	c_unmapped: cover property (take && !mapped);

endmodule : pfl_frac_loop_regs

//--- pfl_frac_loop_regs_tb.sv
// Self-checking bench for the fractional loop register bank.
// Assumes the design answers classic Wishbone and registers every output.
`include "pfl_defs.svh"

module pfl_frac_loop_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pfl_pkg::*;

	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
	logic [3:0]  wb_sel_i;
	logic [21:0] num_o, den_o;
	logic [11:0] ndiv_o;
	pfl_dither_t dith_o;
	pfl_order_t  ord_o;
	logic        int_mode_o, dith_en_o;
	logic [5:0]  r2_o;
	logic [2:0]  c1_o;
	logic [8:0]  c1_pf_o;
	logic [6:0]  r3_o;
	int          failures, checked;
	logic [15:0] lfsr_r;
	logic [7:0]  shadow [8'h49:8'h54];

	pfl_frac_loop_regs dut (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.frac_numerator_o(num_o), .frac_denominator_o(den_o), .integer_feedback_divider_o(ndiv_o),
		.dither_strength_o(dith_o), .modulator_order_o(ord_o), .integer_mode_o(int_mode_o),
		.dither_enable_o(dith_en_o), .loop_resistor_two_code_o(r2_o), .loop_capacitor_one_code_o(c1_o),
		.loop_capacitor_one_pf_o(c1_pf_o), .loop_resistor_three_code_o(r3_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Writable bits per register; everything else is reserved
	function automatic logic [7:0] reg_mask(input logic [7:0] idx);
		case (idx)
			`PFL_IDX_NDIV_HI, `PFL_IDX_MOD: reg_mask = 8'h0F;
			`PFL_IDX_NUM_U, `PFL_IDX_DEN_U, `PFL_IDX_R2: reg_mask = 8'h3F;
			`PFL_IDX_C1: reg_mask = 8'h07;
			`PFL_IDX_R3: reg_mask = 8'h7F;
			default: reg_mask = 8'hFF;
		endcase
	endfunction : reg_mask

	function automatic logic [7:0] reg_reset(input logic [7:0] idx);
		case (idx)
			`PFL_IDX_NDIV_LO: reg_reset = 8'h64;
			`PFL_IDX_MOD: reg_reset = 8'h0C;
			`PFL_IDX_R2: reg_reset = 8'h24;
			default: reg_reset = 8'h00;
		endcase
	endfunction : reg_reset

	function automatic logic [31:0] rnd();
		logic [31:0] v;
		for (int i = 0; i < 32; i++) begin
			lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
			v[i] = lfsr_r[0];
		end
		return v;
	endfunction : rnd

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// Holds the request until ack is sampled high at a rising edge
	task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] wdat,
			input logic [3:0] sel, output logic [31:0] rdat);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wdat;
		wb_sel_i <= sel;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		if (n >= 16) begin
			failures++;
			$display("mismatch wb_ack_o expected 1 seen timeout");
		end
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : wb_xfer

	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] rd;
		wb_xfer(1'b1, {22'h000000, idx, d[31:30]}, d, sel, rd);
		if (sel[0])
			shadow[idx] = d[7:0] & reg_mask(idx);
	endtask : wr

	task automatic rd_check(input logic [7:0] idx);
		logic [31:0] rd;
		wb_xfer(1'b0, {22'h000000, idx, 2'b00}, 32'h0, 4'hF, rd);
		check("read data", rd, {24'h000000, shadow[idx]});
	endtask : rd_check

	// Derived outputs lag the register by one cycle
	task automatic check_outputs;
		repeat (2) @(negedge clk_i);
		check("frac_numerator_o", 32'(num_o), {10'h0, shadow[8'h4B][5:0], shadow[8'h4C], shadow[8'h4D]});
		check("frac_denominator_o", 32'(den_o), {10'h0, shadow[8'h4E][5:0], shadow[8'h4F], shadow[8'h50]});
		check("integer_feedback_divider_o", 32'(ndiv_o), {20'h0, shadow[8'h49][3:0], shadow[8'h4A]});
		check("dither_strength_o", 32'(dith_o), 32'(shadow[8'h51][3:2]));
		check("dither_enable_o", 32'(dith_en_o), 32'(shadow[8'h51][3:2] != 2'h3));
		check("modulator_order_o", 32'(ord_o), 32'(shadow[8'h51][1:0]));
		check("integer_mode_o", 32'(int_mode_o), 32'(shadow[8'h51][1:0] == 2'h0));
		check("loop_resistor_two_code_o", 32'(r2_o), 32'(shadow[8'h52]));
		check("loop_capacitor_one_code_o", 32'(c1_o), 32'(shadow[8'h53]));
		check("loop_capacitor_one_pf_o", 32'(c1_pf_o), 32'h5 + 32'h32 * shadow[8'h53]);
		check("loop_resistor_three_code_o", 32'(r3_o), 32'(shadow[8'h54]));
	endtask : check_outputs

	task automatic reset_and_check;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 8'h49; i <= 8'h54; i++)
			shadow[i] = reg_reset(8'(i));
		check_outputs;
		for (int i = 8'h49; i <= 8'h54; i++)
			rd_check(8'(i));
		$display("test reset values done");
	endtask : reset_and_check

	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		complete_run;
	end

	initial begin
		logic [31:0] r, d;
		static logic [7:0] r2_codes [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h30};
		static logic [7:0] r3_codes [7] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 32'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		failures = 0;
		checked = 0;
		lfsr_r = 16'h050A;
		reset_and_check;
		// Random data includes reserved bits and cleared byte enables
		repeat (48) begin
			r = rnd();
			d = rnd();
			wr(8'h49 + 8'(r[15:0] % 12), d, r[19:16]);
			rd_check(8'h49 + 8'(r[15:0] % 12));
		end
		check_outputs;
		for (int i = 8'h49; i <= 8'h54; i++)
			wr(8'(i), 32'hFFFFFFFF, 4'hF);
		check_outputs;
		for (int i = 8'h49; i <= 8'h54; i++)
			rd_check(8'(i));
		$display("test random and all ones done");
		for (int i = 0; i < 16; i++) begin
			wr(`PFL_IDX_MOD, 32'(i), 4'h1);
			check_outputs;
		end
		for (int i = 0; i < 8; i++) begin
			wr(`PFL_IDX_C1, 32'(i), 4'h1);
			check_outputs;
		end
		foreach (r2_codes[i]) begin
			wr(`PFL_IDX_R2, 32'(r2_codes[i]), 4'h1);
			rd_check(`PFL_IDX_R2);
			check_outputs;
		end
		foreach (r3_codes[i]) begin
			wr(`PFL_IDX_R3, 32'(r3_codes[i]), 4'h1);
			rd_check(`PFL_IDX_R3);
			check_outputs;
		end
		$display("test field codes done");
		// An alias above the register window must not reach the bank
		wb_xfer(1'b1, 32'h00000400 | {22'h0, `PFL_IDX_R2, 2'b00}, 32'h15, 4'hF, d);
		wb_xfer(1'b0, 32'h00000400 | {22'h0, `PFL_IDX_R2, 2'b00}, 32'h0, 4'hF, d);
		check("unmapped read", d, 32'h0);
		wb_xfer(1'b0, {22'h0, 8'h55, 2'b00}, 32'h0, 4'hF, d);
		check("empty index read", d, 32'h0);
		rd_check(`PFL_IDX_R2);
		check_outputs;
		$display("test unmapped done");
		reset_and_check;
		complete_run;
	end
endmodule : pfl_frac_loop_regs_tb

//--- pfl_pkg.sv
// Types shared by the fractional loop register bank and its helpers.
// Assumes pfl_defs.svh is on the include path.
`include "pfl_defs.svh"

package pfl_pkg;

	typedef enum logic [1:0] {
		PFL_DITHER_WEAK   = 2'b00,
		PFL_DITHER_MEDIUM = 2'b01,
		PFL_DITHER_STRONG = 2'b10,
		PFL_DITHER_OFF    = 2'b11
	} pfl_dither_t;

	typedef enum logic [1:0] {
		PFL_ORDER_INTEGER = 2'b00,
		PFL_ORDER_FIRST   = 2'b01,
		PFL_ORDER_SECOND  = 2'b10,
		PFL_ORDER_THIRD   = 2'b11
	} pfl_order_t;

	// Register bank state
	typedef struct packed {
		logic [3:0]  ndiv_hi;
		logic [7:0]  ndiv_lo;
		logic [5:0]  num_u;
		logic [7:0]  num_m;
		logic [7:0]  num_l;
		logic [5:0]  den_u;
		logic [7:0]  den_m;
		logic [7:0]  den_l;
		pfl_dither_t dither;
		pfl_order_t  order;
		logic [5:0]  r2;
		logic [2:0]  c1;
		logic [6:0]  r3;
		logic [31:0] dat;
		logic [21:0] num;
		logic [21:0] den;
		logic [11:0] ndiv;
		logic        int_mode;
		logic        dith_en;
	} pfl_state_t;

	typedef struct packed {
		logic ack;
	} pfl_ack_t;

	typedef struct packed {
		logic [8:0] pf;
	} pfl_cap_t;

endpackage : pfl_pkg

//--- pfl_wb_ack.sv
// Classic Wishbone single-cycle handshake: one ack per request.
// Assumes the master holds cyc and stb until it samples ack.
`include "pfl_defs.svh"

module pfl_wb_ack (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Bus strobes
	input  wire logic cyc_i,
	input  wire logic stb_i,
	// Handshake
	output logic      take_o,
	output logic      ack_o
);
	import pfl_pkg::*;

	pfl_ack_t s_r;
	pfl_ack_t s_nxt;

	// Ack drops after one cycle, so a request released on ack is taken once; one held longer is taken again every other cycle
	always_comb begin
		s_nxt     = s_r;
		s_nxt.ack = cyc_i && stb_i && !s_r.ack;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign take_o = s_nxt.ack;
	assign ack_o  = s_r.ack;

endmodule : pfl_wb_ack
